// File: pwm_timing_pkg.sv
package pwm_timing_pkg;
  localparam int ADDR_W = 6;
  localparam int PERIOD_W = 16;
  localparam int DEAD_W = 10;
  localparam int DUTY_W = 16;
  localparam int OEC_W = 9;
  localparam int CNT_W = 17;
  localparam int CMP_W = 20;
  localparam int CHANNELS = 3;

  localparam logic [ADDR_W-1:0] OFS_PERIOD = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_DEAD = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DUTY0 = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY1 = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_DUTY2 = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_STAT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_OEC = 6'h1C;

  localparam int MODE_BIT = 2;
  localparam int HALF_BIT = 0;

  localparam logic [PERIOD_W-1:0] RST_PERIOD = 16'h0000;
  localparam logic [DEAD_W-1:0] RST_DEAD = 10'h000;
  localparam logic [DUTY_W-1:0] RST_DUTY = 16'h0000;
  localparam logic [OEC_W-1:0] RST_OEC = 9'h000;
  localparam logic RST_MODE = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'h0,
    TMR_START = 2'h1,
    TMR_RUN = 2'h3
  } timer_state_t;

  typedef struct packed {
    logic [CHANNELS-1:0] high_side;
    logic [CHANNELS-1:0] low_side;
  } gate_drive_t;
endpackage

// File: three_phase_pwm_timing_unit.sv
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// R1: one shared 10-bit dead time, all pairs
// R2: dead time equals value times two clocks
// R3: dead time read/write, up to 0x3FF
// R4: zero dead time inserts no gap
// R5: control bit 2 picks mode, single after reset
// R6: single mode: one sync, reloads all shadows
// R7: sync also latches output enable/crossover value
// R8: double mode: extra midpoint sync and reload
// R9: status bit 0 low first half, high second
// R10: three 16-bit duty registers, half-period counts
// R11: outputs active high, high means switch on
// R12: both edges shifted by dead time, symmetric
// R13: on times follow period plus/minus twice terms
// R14: on times clamped between zero and twice period
// R15: double mode period sums both halves
// R16: channels one and two mirror channel zero
// R17: outputs off until period and duties written
// R18: period write starts the main timer
// R19: first sync after 1.5 or 1 period
// R20: period holds half-period clocks, never 0/1
// R21: sync raises an interrupt request
// R22: center-aligned counter compared against thresholds
module three_phase_pwm_timing_unit (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [pwm_timing_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pwm_timing_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output pwm_timing_pkg::gate_drive_t gate_drive,
  output logic period_sync_pulse,
  output logic sync_irq,
  output logic half_cycle,
  output logic [pwm_timing_pkg::OEC_W-1:0] output_enable_latched
);
  import pwm_timing_pkg::*;

  // Byte strobes replace only their own lanes; untouched lanes keep the register value
  function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] ws);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (ws[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus state
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Software registers
  logic [PERIOD_W-1:0] half_period_count;
  logic [DEAD_W-1:0] dead_time_value;
  logic [DUTY_W-1:0] duty_channel_zero;
  logic [DUTY_W-1:0] duty_channel_one;
  logic [DUTY_W-1:0] duty_channel_two;
  logic update_mode;
  logic [OEC_W-1:0] output_enable_crossover;
  logic [3:0] written;

  // Timing unit
  timer_state_t state;
  logic [CNT_W-1:0] cnt;
  logic half;
  logic [PERIOD_W-1:0] act_period;
  logic [DEAD_W-1:0] act_dead;
  logic [DUTY_W-1:0] act_duty [CHANNELS];
  logic [CHANNELS-1:0] hi_cmp;
  logic [CHANNELS-1:0] lo_cmp;

  // Write channel decode
  wire aw_take = s_axi_awready & s_axi_awvalid;
  wire w_take = s_axi_wready & s_axi_wvalid;
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full = (aw_full & ~do_write) | aw_take;
  wire next_w_full = (w_full & ~do_write) | w_take;
  wire next_bvalid = (s_axi_bvalid & ~s_axi_bready) | do_write;
  wire [ADDR_W-3:0] wr_word = aw_addr_q[ADDR_W-1:2];
  wire wr_period = do_write & (wr_word == OFS_PERIOD[ADDR_W-1:2]);
  wire wr_dead = do_write & (wr_word == OFS_DEAD[ADDR_W-1:2]);
  wire wr_duty0 = do_write & (wr_word == OFS_DUTY0[ADDR_W-1:2]);
  wire wr_duty1 = do_write & (wr_word == OFS_DUTY1[ADDR_W-1:2]);
  wire wr_duty2 = do_write & (wr_word == OFS_DUTY2[ADDR_W-1:2]);
  wire wr_ctrl = do_write & (wr_word == OFS_CTRL[ADDR_W-1:2]);
  wire wr_stat = do_write & (wr_word == OFS_STAT[ADDR_W-1:2]);
  wire wr_oec = do_write & (wr_word == OFS_OEC[ADDR_W-1:2]);
  wire wr_hit = wr_period | wr_dead | wr_duty0 | wr_duty1 | wr_duty2 | wr_ctrl | wr_stat | wr_oec;

  wire [31:0] new_period = merge_lanes({16'h0000, half_period_count}, wdata_q, wstrb_q);
  wire [31:0] new_dead = merge_lanes({22'h000000, dead_time_value}, wdata_q, wstrb_q);
  wire [31:0] new_duty0 = merge_lanes({16'h0000, duty_channel_zero}, wdata_q, wstrb_q);
  wire [31:0] new_duty1 = merge_lanes({16'h0000, duty_channel_one}, wdata_q, wstrb_q);
  wire [31:0] new_duty2 = merge_lanes({16'h0000, duty_channel_two}, wdata_q, wstrb_q);
  wire [31:0] ctrl_word = {29'h00000000, update_mode, 2'h0};
  wire [31:0] new_ctrl = merge_lanes(ctrl_word, wdata_q, wstrb_q);
  wire [31:0] new_oec = merge_lanes({23'h000000, output_enable_crossover}, wdata_q, wstrb_q);

  // Read channel decode
  wire ar_take = s_axi_arready & s_axi_arvalid;
  wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire [ADDR_W-3:0] rd_word = s_axi_araddr[ADDR_W-1:2];
  wire [31:0] stat_word = {31'h00000000, half};
  wire rd_hit = (rd_word <= OFS_OEC[ADDR_W-1:2]);
  wire [31:0] rd_value =
    (rd_word == OFS_PERIOD[ADDR_W-1:2]) ? {16'h0000, half_period_count} :
    (rd_word == OFS_DEAD[ADDR_W-1:2]) ? {22'h000000, dead_time_value} :
    (rd_word == OFS_DUTY0[ADDR_W-1:2]) ? {16'h0000, duty_channel_zero} :
    (rd_word == OFS_DUTY1[ADDR_W-1:2]) ? {16'h0000, duty_channel_one} :
    (rd_word == OFS_DUTY2[ADDR_W-1:2]) ? {16'h0000, duty_channel_two} :
    (rd_word == OFS_CTRL[ADDR_W-1:2]) ? ctrl_word :
    (rd_word == OFS_STAT[ADDR_W-1:2]) ? stat_word :
    (rd_word == OFS_OEC[ADDR_W-1:2]) ? {23'h000000, output_enable_crossover} :
    32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_bvalid <= next_bvalid;
      // Ready drops while a response is pending, so only one write is ever in flight
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready <= ~next_w_full & ~next_bvalid;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rdata <= rd_value;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      half_period_count <= RST_PERIOD;
      dead_time_value <= RST_DEAD;
      duty_channel_zero <= RST_DUTY;
      duty_channel_one <= RST_DUTY;
      duty_channel_two <= RST_DUTY;
      update_mode <= RST_MODE; // R5
      output_enable_crossover <= RST_OEC;
      written <= 4'h0;
    end else begin
      if (wr_period) begin
        half_period_count <= new_period[PERIOD_W-1:0];
      end
      if (wr_dead) begin
        dead_time_value <= new_dead[DEAD_W-1:0]; // R3
      end
      if (wr_duty0) begin
        duty_channel_zero <= new_duty0[DUTY_W-1:0]; // R10
      end
      if (wr_duty1) begin
        duty_channel_one <= new_duty1[DUTY_W-1:0]; // R10
      end
      if (wr_duty2) begin
        duty_channel_two <= new_duty2[DUTY_W-1:0]; // R10
      end
      if (wr_ctrl) begin
        update_mode <= new_ctrl[MODE_BIT]; // R5
      end
      if (wr_oec) begin
        output_enable_crossover <= new_oec[OEC_W-1:0];
      end
      written <= written | {wr_duty2, wr_duty1, wr_duty0, wr_period}; // R17
    end
  end

  // Counter sequencing: half 0 counts up to period-1, half 1 counts back down to 0
  wire all_written = (written == 4'hF);
  wire start_done = (state == TMR_START) && (cnt == '0);
  wire run_state = (state == TMR_RUN);
  wire [CNT_W-1:0] act_last = {1'b0, act_period - 16'h0001}; // R20
  wire end_first = run_state && !half && (cnt == act_last);
  wire end_second = run_state && half && (cnt == '0);
  wire load_now = start_done | end_second | (end_first & update_mode); // R6 R8
  wire [CNT_W-1:0] p_ext = {1'b0, new_period[PERIOD_W-1:0]};
  wire [CNT_W-1:0] p_half = {2'h0, new_period[PERIOD_W-1:1]};
  wire [CNT_W-1:0] start_len = update_mode ? p_ext : p_ext + p_half; // R19
  // Mode is read live, so a mode write takes effect at the next midpoint
  wire [CNT_W-1:0] mid_last = update_mode ? {1'b0, half_period_count - 16'h0001} : act_last; // R15
  wire live = all_written && run_state; // R17

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= TMR_IDLE;
      cnt <= '0;
      half <= 1'b0;
      act_period <= RST_PERIOD;
      act_dead <= RST_DEAD;
      output_enable_latched <= RST_OEC;
      period_sync_pulse <= 1'b0;
      sync_irq <= 1'b0;
      half_cycle <= 1'b0;
    end else begin
      period_sync_pulse <= load_now;
      sync_irq <= load_now; // R21
      half_cycle <= half; // R9
      if (load_now) begin
        act_period <= half_period_count; // R6 R8
        act_dead <= dead_time_value; // R1 R6
        output_enable_latched <= output_enable_crossover; // R7
      end
      case (state)
        TMR_IDLE: begin
          if (wr_period) begin
            state <= TMR_START; // R18
            cnt <= start_len - 17'h00001; // R19
          end
        end
        TMR_START: begin
          if (start_done) begin
            state <= TMR_RUN;
            cnt <= '0;
            half <= 1'b0;
          end else begin
            cnt <= cnt - 17'h00001;
          end
        end
        TMR_RUN: begin
          if (end_first) begin
            half <= 1'b1; // R9
            cnt <= mid_last;
          end else if (end_second) begin
            half <= 1'b0; // R9
            cnt <= '0;
          end else if (half) begin
            cnt <= cnt - 17'h00001; // R22
          end else begin
            cnt <= cnt + 17'h00001; // R22
          end
        end
        default: begin
          state <= TMR_IDLE;
          cnt <= '0;
          half <= 1'b0;
        end
      endcase
    end
  end

  // Comparison at the middle of each clock keeps both halves mirror images
  wire signed [CMP_W-1:0] pos2 = $signed({2'h0, cnt, 1'b1});
  wire signed [CMP_W-1:0] per_s = $signed({4'h0, act_period});
  wire signed [CMP_W-1:0] dead2 = $signed({9'h000, act_dead, 1'b0}); // R2

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    wire [DUTY_W-1:0] duty_sw = (ch == 0) ? duty_channel_zero : (ch == 1) ? duty_channel_one : duty_channel_two;
    wire signed [CMP_W-1:0] duty2 = $signed({3'h0, act_duty[ch], 1'b0});
    // Dead time pushes the high edge later and the low edge earlier by the same amount
    wire signed [CMP_W-1:0] th_high = per_s - duty2 + dead2; // R4 R12 R13
    wire signed [CMP_W-1:0] th_low = per_s - duty2 - dead2; // R4 R12 R13
    // Thresholds outside the count range give 0% or 100% without extra clamps
    assign hi_cmp[ch] = (pos2 >= th_high); // R14 R16 R22
    assign lo_cmp[ch] = (pos2 < th_low); // R14 R16 R22

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        act_duty[ch] <= RST_DUTY;
      end else if (load_now) begin
        act_duty[ch] <= duty_sw; // R6 R8 R16
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gate_drive <= '0;
    end else begin
      gate_drive.high_side <= live ? hi_cmp : '0; // R11 R17
      gate_drive.low_side <= live ? lo_cmp : '0; // R11 R17
    end
  end

  if (CHANNELS != 3 || DEAD_W > CMP_W - 8 || PERIOD_W + 1 != CNT_W) begin : g_bad_params
    $error("unsupported width or channel constants");
  end

  mode_default_a: assert property (@(posedge clk_sys) disable iff (reset) // R5
    $past(reset) |-> !update_mode)
    else $error("update mode not single after reset");

  idle_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // R17
    !all_written |-> (gate_drive == '0))
    else $error("outputs active before all registers written");

  pair_gap_a: assert property (@(posedge clk_sys) disable iff (reset) // R12
    ($past(act_dead) != '0) |-> ((gate_drive.high_side & gate_drive.low_side) == '0))
    else $error("both switches of a pair on with dead time set");

  zero_dead_a: assert property (@(posedge clk_sys) disable iff (reset) // R4
    ($past(act_dead) == '0) && $past(live) |-> (gate_drive.low_side == ~gate_drive.high_side))
    else $error("gap inserted with zero dead time");

  sync_load_a: assert property (@(posedge clk_sys) disable iff (reset) // R6
    period_sync_pulse |-> (act_period == $past(half_period_count)) && (act_dead == $past(dead_time_value)))
    else $error("shadows not loaded at sync");

  enable_latch_a: assert property (@(posedge clk_sys) disable iff (reset) // R7
    period_sync_pulse |-> (output_enable_latched == $past(output_enable_crossover)))
    else $error("output enable value not latched at sync");

  single_sync_a: assert property (@(posedge clk_sys) disable iff (reset) // R6
    period_sync_pulse && !$past(update_mode) |-> !half)
    else $error("midpoint sync in single update mode");

  mid_sync_a: assert property (@(posedge clk_sys) disable iff (reset) // R8
    $rose(half) && $past(update_mode) |-> period_sync_pulse && sync_irq)
    else $error("no midpoint sync in double update mode");

  half_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // R9
    $fell(half) |-> period_sync_pulse ##1 half_cycle == 1'b0)
    else $error("half status cleared away from period start");

  timer_start_a: assert property (@(posedge clk_sys) disable iff (reset) // R18
    (state == TMR_IDLE) && wr_period |=> (state == TMR_START))
    else $error("period write did not start the timer");

  mid_reload_a: assert property (@(posedge clk_sys) disable iff (reset) // R15
    $rose(half) && $past(update_mode) |-> (act_period == $past(half_period_count)) && (cnt == {1'b0, act_period - 16'h0001}))
    else $error("second half not timed by the reloaded period");

  irq_pair_a: assert property (@(posedge clk_sys) disable iff (reset) // R21
    sync_irq == period_sync_pulse)
    else $error("interrupt request not paired with sync");

endmodule // three_phase_pwm_timing_unit

// File: gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
  input wire logic clk_sys,
  input wire logic clear,
  input wire pwm_timing_pkg::gate_drive_t gate_drive,
  output int high_on [pwm_timing_pkg::CHANNELS],
  output int low_on [pwm_timing_pkg::CHANNELS],
  output int overlap
);
  import pwm_timing_pkg::*;
  // Switch-on time per leg, a high level turning the switch on
  always @(posedge clk_sys) begin
    if (clear) begin
      overlap <= 0;
      for (int i = 0; i < CHANNELS; i++) begin
        high_on[i] <= 0;
        low_on[i] <= 0;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        high_on[i] <= high_on[i] + int'(gate_drive.high_side[i]);
        low_on[i] <= low_on[i] + int'(gate_drive.low_side[i]);
        // Both switches of one leg on would short the dc link
        if (gate_drive.high_side[i] && gate_drive.low_side[i]) begin
          overlap <= overlap + 1;
        end
      end
    end
  end
endmodule // gate_driver_model

// File: test_three_phase_pwm_timing_unit.sv
`timescale 1ns/1ps
module test_three_phase_pwm_timing_unit;
  import pwm_timing_pkg::*;
  localparam int P = 8;
  logic clk_sys = 1'h0;
  logic reset, clear, awv, wv, bry, arv, rry;
  logic [ADDR_W-1:0] aw, ar;
  logic [31:0] wd, rd;
  logic [3:0] ws;
  logic awr, wr, bv, arr, rv, sync, irq, half, irq_bad;
  logic [1:0] br, rr;
  logic [OEC_W-1:0] oel;
  logic [5:0] seen;
  gate_drive_t gd;
  int high_on [CHANNELS];
  int low_on [CHANNELS];
  int overlap, bad_count, n_checks, n;

  always #12.5 clk_sys = ~clk_sys;

  three_phase_pwm_timing_unit dut (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .gate_drive(gd), .period_sync_pulse(sync), .sync_irq(irq),
    .half_cycle(half), .output_enable_latched(oel));

  gate_driver_model drv (.clk_sys(clk_sys), .clear(clear), .gate_drive(gd), .high_on(high_on),
    .low_on(low_on), .overlap(overlap));

  task automatic test_done();
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic give_up();
    bad_count++;
    test_done();
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    int k = 0;
    @(posedge clk_sys);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk_sys);
      k++;
      if (awr === 1'h1) awv <= 1'h0;
      if (wr === 1'h1) wv <= 1'h0;
      if (bv === 1'h1) bry <= 1'h0;
    end while (bv !== 1'h1 && k < 50);
    if (k >= 50) give_up();
    check(br, er);
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k = 0;
    @(posedge clk_sys);
    ar <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk_sys);
      k++;
      if (arr === 1'h1) arv <= 1'h0;
      if (rv === 1'h1) rry <= 1'h0;
    end while (rv !== 1'h1 && k < 50);
    if (k >= 50) give_up();
    check(rd, ed);
    check(rr, er);
  endtask

  // Counts edges up to the next sync; also records any drive seen on the way
  task automatic wait_sync(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
      seen = seen | gd;
      if (irq !== sync) irq_bad = 1'h1;
    end while (sync !== 1'h1 && c < 400);
    if (c >= 400) give_up();
  endtask

  function automatic int clamp(input int v);
    return (v < 0) ? 0 : ((v > 2 * P) ? 2 * P : v);
  endfunction

  // Any window of one full period sees the whole on time once shadows are steady
  task automatic measure(input int d0, input int d1, input int d2, input int dt);
    int d [CHANNELS] = '{d0, d1, d2};
    wait_sync(n);
    wait_sync(n);
    clear <= 1'h1;
    @(posedge clk_sys);
    clear <= 1'h0;
    repeat (2 * P) @(posedge clk_sys);
    #1;
    for (int i = 0; i < CHANNELS; i++) begin
      check(high_on[i], clamp(P + 2 * (d[i] - dt)));
      check(low_on[i], clamp(P - 2 * (d[i] + dt)));
    end
    check(overlap, 32'h0);
  endtask

  task automatic t_regs();
    rd_reg(OFS_DEAD, 32'h0, RESP_OKAY);
    rd_reg(OFS_CTRL, 32'h0, RESP_OKAY);
    wr_reg(OFS_DEAD, 32'hFFFF_FFFF, RESP_OKAY);
    rd_reg(OFS_DEAD, 32'h3FF, RESP_OKAY);
    wr_reg(OFS_DUTY0, 32'h0001_2345, RESP_OKAY);
    rd_reg(OFS_DUTY0, 32'h2345, RESP_OKAY);
    wr_reg(6'h20, 32'h1, RESP_SLVERR);
    rd_reg(6'h24, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_start();
    wr_reg(OFS_PERIOD, P, RESP_OKAY);
    wait_sync(n);
    check(n >= 11 && n <= 13, 1'h1);
    wait_sync(n);
    check(n, 2 * P);
    check(seen, 6'h00);
  endtask

  task automatic t_single();
    wr_reg(OFS_DEAD, 32'h1, RESP_OKAY);
    wr_reg(OFS_DUTY0, 32'h1, RESP_OKAY);
    wr_reg(OFS_DUTY1, 32'h2, RESP_OKAY);
    wr_reg(OFS_DUTY2, 32'h0, RESP_OKAY);
    measure(1, 2, 0, 1);
    wait_sync(n);
    repeat (3) @(posedge clk_sys);
    check(half, 1'h0);
    rd_reg(OFS_STAT, 32'h0, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    rd_reg(OFS_STAT, 32'h1, RESP_OKAY);
    repeat (3) @(posedge clk_sys);
    check(half, 1'h1);
  endtask

  task automatic t_extremes();
    wr_reg(OFS_DEAD, 32'h0, RESP_OKAY);
    wr_reg(OFS_DUTY0, 32'h9, RESP_OKAY);
    wr_reg(OFS_DUTY2, 32'h2, RESP_OKAY);
    wr_reg(OFS_DUTY1, 32'h0, RESP_OKAY);
    measure(9, 0, 2, 0);
    wait_sync(n);
    wr_reg(OFS_OEC, 32'h1A5, RESP_OKAY);
    check(oel, 9'h000);
    wait_sync(n);
    #1;
    check(oel, 9'h1A5);
  endtask

  task automatic t_double();
    wr_reg(OFS_CTRL, 32'h4, RESP_OKAY);
    rd_reg(OFS_CTRL, 32'h4, RESP_OKAY);
    wait_sync(n);
    wait_sync(n);
    check(n, P);
    measure(9, 0, 2, 0);
  endtask

  // Midpoint reload gives two different halves inside one measured window
  task automatic t_asym();
    wr_reg(OFS_DUTY0, 32'h1, RESP_OKAY);
    wait_sync(n);
    clear <= 1'h1;
    @(posedge clk_sys);
    clear <= 1'h0;
    wr_reg(OFS_DUTY0, 32'h3, RESP_OKAY);
    wait_sync(n);
    wr_reg(OFS_DUTY0, 32'h1, RESP_OKAY);
    repeat (5) @(posedge clk_sys);
    #1;
    check(high_on[0], P + 1 + 3);
    check(low_on[0], P - 1 - 3);
    check(overlap, 32'h0);
  endtask

  // Second reset in mid-run: mode and written flags return to idle
  task automatic t_restart();
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    seen = 6'h00;
    rd_reg(OFS_CTRL, 32'h0, RESP_OKAY);
    wr_reg(OFS_CTRL, 32'h4, RESP_OKAY);
    wr_reg(OFS_PERIOD, P, RESP_OKAY);
    wait_sync(n);
    check(n, P);
    wait_sync(n);
    check(n, P);
    check(seen, 6'h00);
  endtask

  initial begin
    reset = 1'h1;
    clear = 1'h1;
    {awv, wv, bry, arv, rry} = 5'h00;
    aw = 6'h00;
    ar = 6'h00;
    wd = 32'h0;
    ws = 4'hF;
    seen = 6'h00;
    irq_bad = 1'h0;
    bad_count = 0;
    n_checks = 0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    t_regs();
    t_start();
    t_single();
    t_extremes();
    t_double();
    t_asym();
    t_restart();
    check(irq_bad, 1'h0);
    test_done();
  end
endmodule // test_three_phase_pwm_timing_unit
